// [eccpr_router.sv]
// Purpose: Output routing, timer choice and special event trigger for three
//   enhanced capture/compare/PWM units
// Assumes: Waveforms come from the unit cores; config inputs static
//   Capture pins are inputs; the router never drives them
// Notes: Every pin output is registered so the handover is glitch free
//   Port H pins are shared by units 1 and 3; unit 3 wins a clash
`timescale 1ns/1ps
`default_nettype none
module eccpr_router
  import eccpr_pkg::*;
#(
  parameter bit LARGE_PKG = 1'b1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire eccpr_unit_t unit [NUM_UNITS],
  input wire logic eccp2_pin_select,
  input wire logic eccp13_pin_select,
  input wire logic [1:0] memory_mode_config,
  input wire logic adc_enabled,
  input wire logic [15:0] timer_a_count,
  input wire logic [15:0] timer_b_count,
  input wire logic pwm_timer_a_match,
  input wire logic pwm_timer_b_match,
  input wire logic std_ccp_unit_a_out,
  input wire logic std_ccp_unit_b_out,
  // Port latch fallbacks, indexed by pin_id below
  input wire logic [15:0] port_latch,
  // Routed pins: 0 c2,1 e6,2 e5,3 g4,4 h7,5 h6,6 c1,7 e7,8 b3,9 e2,
  // 10 e1,11 e0,12 g0,13 e4,14 e3,15 g3
  output logic [15:0] pin_out,
  output logic [15:0] pin_claimed,
  output logic [NUM_UNITS-1:0] special_trigger,
  output logic timer_a_reset,
  output logic timer_b_reset,
  output logic timer_flag_block,
  output logic adc_start,
  output logic [NUM_UNITS-1:0] pwm_period_tick
);

  // PWM modes all have 11 in the top two mode bits
  function automatic logic is_pwm(input logic [7:0] c);
    return c[MODE_HI:MODE_HI-1] == MODE_PWM_TOP;
  endfunction : is_pwm

  // Special event code; only units 1 and 2 act on it
  function automatic logic is_spe(input logic [7:0] c);
    return c[MODE_HI:MODE_LO] == MODE_CMP_SPE;
  endfunction : is_spe

  // Compare codes that drive the pin. Capture pins stay inputs, and
  // 1010/1011 hand the pin back to the port, so neither is claimed
  function automatic logic cmp_drives_pin(input logic [7:0] c);
    logic d;
    case (c[MODE_HI:MODE_LO])
      MODE_CMP_TGL: d = 1'b1;
      MODE_CMP_SET: d = 1'b1;
      MODE_CMP_CLR: d = 1'b1;
      default: d = 1'b0;
    endcase
    return d;
  endfunction : cmp_drives_pin

  // Effective output setup after mode restriction
  function automatic eccpr_outs_t pattern(input eccpr_unit_t u,
                                          input logic force_single);
    eccpr_outs_t o;
    logic [1:0] oc;
    logic pa;
    logic pb;
    o = '0;
    oc = force_single ? OCFG_SINGLE : u.ctrl[CFG_HI:CFG_LO];
    // Low bit inverts b/d, next bit inverts a/c
    pa = u.ctrl[1];
    pb = u.ctrl[0];
    // Full-bridge setups hold unused outputs at their inactive level; single and half leave them unclaimed
    if (is_pwm(u.ctrl)) begin
      case (oc)
        OCFG_SINGLE: begin
          o.out_a = u.pwm_raw ^ pa;
          o.en_a = 1'b1;
        end
        OCFG_HALF: begin
          o.out_a = u.pwm_raw ^ pa;
          o.out_b = u.pwm_raw_n ^ pb;
          o.en_a = 1'b1;
          o.en_b = 1'b1;
        end
        OCFG_FWD: begin
          o.out_a = 1'b1 ^ pa;
          o.out_b = pb;
          o.out_c = pa;
          o.out_d = u.pwm_raw ^ pb;
          {o.en_a, o.en_b, o.en_c, o.en_d} = 4'hf;
        end
        default: begin
          o.out_a = pa;
          o.out_b = u.pwm_raw ^ pb;
          o.out_c = 1'b1 ^ pa;
          o.out_d = pb;
          {o.en_a, o.en_b, o.en_c, o.en_d} = 4'hf;
        end
      endcase
    end else if (cmp_drives_pin(u.ctrl)) begin
      // Compare drive on out_a as in the standard unit
      o.out_a = u.cmp_pin;
      o.en_a = 1'b1;
    end
    return o;
  endfunction : pattern

  logic micro;
  logic restrict13;
  eccpr_outs_t o1;
  eccpr_outs_t o2;
  eccpr_outs_t o3;
  logic [15:0] drv;
  logic [15:0] claim;
  logic [15:0] drv2;
  logic [15:0] claim2;

  assign micro = (memory_mode_config == MEM_MICRO);
  // Non-micro with select set degrades units 1 and 3
  assign restrict13 = eccp2_pin_select & ~micro & LARGE_PKG;
  assign o1 = pattern(unit[0], restrict13);
  assign o2 = pattern(unit[1], 1'b0);
  assign o3 = pattern(unit[2], restrict13);

  // Pin map; the default claim is the standard or port function
  always_comb begin
    drv = port_latch;
    claim = '0;
    drv[3] = std_ccp_unit_b_out;
    drv[15] = std_ccp_unit_a_out;
    // Unit 1 primary and d output
    if (o1.en_a) begin drv[0] = o1.out_a; claim[0] = 1'b1; end
    if (o1.en_d) begin drv[3] = o1.out_d; claim[3] = 1'b1; end
    // Unit 3 primary and d output
    if (o3.en_a) begin drv[12] = o3.out_a; claim[12] = 1'b1; end
    if (o3.en_d) begin drv[15] = o3.out_d; claim[15] = 1'b1; end
    // Port E pins whenever port H is not selected
    if (!LARGE_PKG || eccp13_pin_select || !micro) begin
      if (o1.en_b) begin drv[1] = o1.out_b; claim[1] = 1'b1; end
      if (o1.en_c) begin drv[2] = o1.out_c; claim[2] = 1'b1; end
      if (o3.en_b) begin drv[13] = o3.out_b; claim[13] = 1'b1; end
      if (o3.en_c) begin drv[14] = o3.out_c; claim[14] = 1'b1; end
    end else begin
      // Port H pins; units 1 and 3 share them in this mode
      if (o1.en_b) begin drv[4] = o1.out_b; claim[4] = 1'b1; end
      if (o1.en_c) begin drv[5] = o1.out_c; claim[5] = 1'b1; end
      if (o3.en_b) begin drv[4] = o3.out_b; claim[4] = 1'b1; end
      if (o3.en_c) begin drv[5] = o3.out_c; claim[5] = 1'b1; end
    end
    // Unit 2 pins never overlap units 1 and 3, so a plain merge
    drv = (drv & ~claim2) | (drv2 & claim2);
    claim = claim | claim2;
  end

  // Unit 2 routing on its own; the unit 1/3 restriction never reaches it
  always_comb begin
    drv2 = '0;
    claim2 = '0;
    // Primary pin by select and program-memory mode
    if (o2.en_a) begin
      if (micro && eccp2_pin_select) begin
        drv2[6] = o2.out_a;
        claim2[6] = 1'b1;
      end else if (micro) begin
        drv2[7] = o2.out_a;
        claim2[7] = 1'b1;
      end else begin
        drv2[8] = o2.out_a;
        claim2[8] = 1'b1;
      end
    end
    // Dedicated b/c/d pins, free whenever the unit leaves them
    if (o2.en_b) begin
      drv2[9] = o2.out_b;
      claim2[9] = 1'b1;
    end
    if (o2.en_c) begin
      drv2[10] = o2.out_c;
      claim2[10] = 1'b1;
    end
    if (o2.en_d) begin
      drv2[11] = o2.out_d;
      claim2[11] = 1'b1;
    end
  end

  // Registered pin levels: one flop stage removes decode hazards
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_out <= 16'h0000;
    end else begin
      pin_out <= drv;
    end
  end

  // Registered claims, kept in step with the levels above
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_claimed <= 16'h0000;
    end else begin
      pin_claimed <= claim;
    end
  end

  // Special event compare match per unit
  logic [NUM_UNITS-1:0] match;
  genvar g;
  generate
    for (g = 0; g < NUM_UNITS; g++) begin : g_cmp
      logic [15:0] cnt;
      assign cnt = unit[g].timer_sel ? timer_b_count : timer_a_count;
      // Unit 3 has no trigger; its 1011 equals 1010
      assign match[g] = (g != 2) &&
        is_spe(unit[g].ctrl) &&
        cnt == unit[g].compare_value_pair;
    end
  endgenerate

  // Edge of a match gives a one-cycle pulse, holding timer stays one event
  logic [NUM_UNITS-1:0] match_r;
  always_ff @(posedge mclk) begin
    if (rst) begin
      match_r <= '0;
      special_trigger <= '0;
    end else begin
      match_r <= match;
      special_trigger <= match & ~match_r;
    end
  end

  // Timer reset and converter start
  logic [NUM_UNITS-1:0] fire;
  assign fire = match & ~match_r;

  // Reset request per unit to the timer it has selected
  logic [NUM_UNITS-1:0] req_a;
  logic [NUM_UNITS-1:0] req_b;
  generate
    for (g = 0; g < NUM_UNITS; g++) begin : g_req
      assign req_a[g] = fire[g] & ~unit[g].timer_sel;
      assign req_b[g] = fire[g] & unit[g].timer_sel;
    end
  endgenerate
  always_ff @(posedge mclk) begin
    if (rst) begin
      timer_a_reset <= 1'b0;
      timer_b_reset <= 1'b0;
      timer_flag_block <= 1'b0;
      adc_start <= 1'b0;
    end else begin
      timer_a_reset <= |req_a;
      timer_b_reset <= |req_b;
      // Suppress overflow flags for a unit 2 reset only
      timer_flag_block <= fire[1];
      adc_start <= fire[1] & adc_enabled;
    end
  end

  // PWM timer choice per unit; the tick only has meaning in PWM modes
  logic [NUM_UNITS-1:0] pwm_sel_match;
  generate
    for (g = 0; g < NUM_UNITS; g++) begin : g_pwm
      assign pwm_sel_match[g] = unit[g].timer_sel ?
        pwm_timer_b_match : pwm_timer_a_match;
    end
  endgenerate

  // PWM period tick, one cycle behind the chosen timer match
  always_ff @(posedge mclk) begin
    if (rst) begin
      pwm_period_tick <= '0;
    end else begin
      pwm_period_tick <= pwm_sel_match;
    end
  end

endmodule : eccpr_router
`default_nettype wire

// [eccpr_pkg.sv]
// Purpose: Shared constants and types for the enhanced CCP output router
// Assumes: Control fields follow the unit control byte layout
// Notes: Pin lists are per-unit bundles of four outputs
package eccpr_pkg;
  // Control byte field positions
  localparam int CFG_HI = 7;
  localparam int CFG_LO = 6;
  localparam int MODE_HI = 3;
  localparam int MODE_LO = 0;
  // Mode codes
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_CMP_SW = 4'ha;
  localparam logic [3:0] MODE_CMP_SPE = 4'hb;
  localparam logic [3:0] MODE_CMP_TGL = 4'h2;
  localparam logic [3:0] MODE_CMP_SET = 4'h8;
  localparam logic [3:0] MODE_CMP_CLR = 4'h9;
  localparam logic [1:0] MODE_PWM_TOP = 2'h3;
  // Output configuration codes
  localparam logic [1:0] OCFG_SINGLE = 2'h0;
  localparam logic [1:0] OCFG_FWD = 2'h1;
  localparam logic [1:0] OCFG_HALF = 2'h2;
  localparam logic [1:0] OCFG_REV = 2'h3;
  // Program-memory mode: microcontroller code in the low config bits
  localparam logic [1:0] MEM_MICRO = 2'h3;
  localparam int NUM_UNITS = 3;
  localparam logic [15:0] TIMER_RESET = 16'h0000;

  // Per-unit control and raw waveform
  typedef struct packed {
    logic [7:0] ctrl;
    logic [15:0] compare_value_pair;
    logic timer_sel;
    logic pwm_raw;
    logic pwm_raw_n;
    logic cmp_pin;
  } eccpr_unit_t;

  // Four unit outputs after pattern and polarity
  typedef struct packed {
    logic out_a;
    logic out_b;
    logic out_c;
    logic out_d;
    logic en_a;
    logic en_b;
    logic en_c;
    logic en_d;
  } eccpr_outs_t;
endpackage : eccpr_pkg

// [eccpr_properties.sv]
// Purpose: Timing checks on the enhanced CCP output router ports
// Assumes: One clock, synchronous active-high reset
// Notes: Pin indices follow the router pin map
`timescale 1ns/1ps
`default_nettype none
module eccpr_properties
  import eccpr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire eccpr_unit_t unit [NUM_UNITS],
  input wire logic eccp2_pin_select,
  input wire logic eccp13_pin_select,
  input wire logic [1:0] memory_mode_config,
  input wire logic adc_enabled,
  input wire logic [15:0] timer_a_count,
  input wire logic [15:0] timer_b_count,
  input wire logic [15:0] port_latch,
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_claimed,
  input wire logic [NUM_UNITS-1:0] special_trigger,
  input wire logic timer_a_reset,
  input wire logic timer_b_reset,
  input wire logic timer_flag_block,
  input wire logic adc_start
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic micro;
  logic hit1;
  // Second unit match; only the first matching cycle should fire
  assign micro = memory_mode_config == MEM_MICRO;
  assign hit1 = unit[1].ctrl[3:0] == MODE_CMP_SPE &&
    (unit[1].timer_sel ? timer_b_count : timer_a_count) ==
    unit[1].compare_value_pair;
  sequence s_hit1; !hit1 ##1 hit1; endsequence
  property p_trig; s_hit1 |=> special_trigger[1]; endproperty
  a_trig: assert property (p_trig)
    else $error("missing trigger");
  property p_treset; s_hit1 |=> timer_flag_block &&
    timer_b_reset == $past(unit[1].timer_sel) &&
    timer_a_reset != $past(unit[1].timer_sel); endproperty
  a_treset: assert property (p_treset)
    else $error("wrong timer reset");
  property p_adc; s_hit1 |=> adc_start == $past(adc_enabled); endproperty
  a_adc: assert property (p_adc)
    else $error("wrong converter start");
  property p_notrig3; special_trigger[2] == 1'b0; endproperty
  a_notrig3: assert property (p_notrig3)
    else $error("third unit fired");
  property p_route; unit[1].ctrl == 8'h0c |=> pin_claimed[8:6] ==
    (!$past(micro) ? 3'b100 : $past(eccp2_pin_select) ? 3'b001 : 3'b010);
  endproperty
  a_route: assert property (p_route)
    else $error("primary pin wrong");
  property p_quad; unit[0].ctrl == 8'h4c && micro |=>
    pin_claimed[3] && pin_out[3] == $past(unit[0].pwm_raw); endproperty
  a_quad: assert property (p_quad)
    else $error("out_d not on standard pin");
  property p_single; eccp2_pin_select && !micro |=>
    pin_claimed[5:1] == 5'h0 && pin_claimed[15:13] == 3'h0; endproperty
  a_single: assert property (p_single)
    else $error("extra outputs claimed");
  property p_pol; unit[0].ctrl[7:2] == 6'h23 && micro && eccp13_pin_select
    |=> pin_out[1:0] == ({$past(unit[0].pwm_raw_n), $past(unit[0].pwm_raw)}
    ^ {$past(unit[0].ctrl[0]), $past(unit[0].ctrl[1])}); endproperty
  a_pol: assert property (p_pol)
    else $error("half bridge level wrong");
  property p_fall; unit[0].ctrl == 8'h00 |=>
    !pin_claimed[0] && pin_out[0] == $past(port_latch[0]); endproperty
  a_fall: assert property (p_fall)
    else $error("no fallback");
endmodule : eccpr_properties
bind eccpr_router eccpr_properties u_props (.mclk(mclk), .rst(rst),
  .unit(unit), .eccp2_pin_select(eccp2_pin_select),
  .eccp13_pin_select(eccp13_pin_select),
  .memory_mode_config(memory_mode_config), .adc_enabled(adc_enabled),
  .timer_a_count(timer_a_count), .timer_b_count(timer_b_count),
  .port_latch(port_latch), .pin_out(pin_out), .pin_claimed(pin_claimed),
  .special_trigger(special_trigger), .timer_a_reset(timer_a_reset),
  .timer_b_reset(timer_b_reset), .timer_flag_block(timer_flag_block),
  .adc_start(adc_start));
`default_nettype wire

// [eccpr_load.sv]
// Purpose: Loads hanging on the routed pins
// Assumes: Software clears direction bits of PWM pins
// Notes: A pad left as input shows a changing level, not the last one
`timescale 1ns/1ps
`default_nettype none
module eccpr_load (
  input wire logic mclk,
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_direction_bits,
  output logic [15:0] pad_level
);
  logic tog_r = 1'b0;
  // Toggling level so a floating pad never passes for a driven one
  always_ff @(posedge mclk) tog_r <= !tog_r;
  assign pad_level = (pin_out & ~pin_direction_bits) |
    ({16{tog_r}} & pin_direction_bits);
endmodule : eccpr_load
`default_nettype wire

// [eccpr_router_tb.sv]
// Purpose: Self-checking bench for the enhanced CCP output router
// Assumes: Inputs change on the falling edge
// Notes: Outputs are compared one cycle after each setting
`timescale 1ns/1ps
`default_nettype none
module eccpr_router_tb;
  import eccpr_pkg::*;
  logic mclk = 0, rst = 1, s2 = 0, s13 = 1, adc = 0;
  logic pma = 0, pmb = 0, sa = 0, sb = 0;
  logic [1:0] mm = 2'h0;
  logic [15:0] ta = 16'h0000, tcb = 16'h0000, pl = 16'h0000;
  logic [15:0] po, pc, pad;
  logic [2:0] st, tick;
  logic tra, trb, tfb, ast;
  int miscompares = 0, checks = 0;
  eccpr_unit_t u [NUM_UNITS] = '{default: '0};
  always #4 mclk = ~mclk;
  eccpr_router dut (.mclk(mclk), .rst(rst), .unit(u),
    .eccp2_pin_select(s2), .eccp13_pin_select(s13),
    .memory_mode_config(mm), .adc_enabled(adc), .timer_a_count(ta),
    .timer_b_count(tcb), .pwm_timer_a_match(pma), .pwm_timer_b_match(pmb),
    .std_ccp_unit_a_out(sa), .std_ccp_unit_b_out(sb), .port_latch(pl),
    .pin_out(po), .pin_claimed(pc), .special_trigger(st),
    .timer_a_reset(tra), .timer_b_reset(trb), .timer_flag_block(tfb),
    .adc_start(ast), .pwm_period_tick(tick));
  // Direction bits held clear so every claimed pin reaches its load
  eccpr_load load (.mclk(mclk), .pin_out(po),
    .pin_direction_bits(16'h0000), .pad_level(pad));
  task automatic chk(input string n, input logic [15:0] e, g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Write one control byte and let the registered outputs settle
  task automatic put(input int i, input logic [7:0] c);
    u[i].ctrl = c;
    @(negedge mclk);
  endtask : put
  task automatic give_verdict;
    if (miscompares == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict
  // Whole run is well under 200 cycles
  initial begin
    repeat (500) @(posedge mclk);
    miscompares++;
    give_verdict();
  end
  initial begin
    repeat (16) @(negedge mclk);
    rst = 0;
    @(negedge mclk);
    chk("reset", 16'h0000, pc);
    chk("reset pins", 16'h0000, po);
    chk("reset pulses", 16'h0000, 16'({st, tra, trb, tfb, ast, tick}));
    foreach (u[i]) u[i].pwm_raw = 1'b1;
    for (int k = 0; k < 4; k++) begin
      s2 = k[0];
      mm = k[1] ? MEM_MICRO : 2'h0;
      put(1, 8'h0c);
      chk("p2a", k[1] ? (k[0] ? 16'h0040 : 16'h0080) : 16'h0100,
        pc & 16'h01c0);
    end
    mm = 2'h0;
    sb = 1;
    u[1].ctrl = 8'h4c;
    put(0, 8'h4c);
    chk("nonmicro", 16'h0f00, pc & 16'h0f3e);
    chk("std pin", 16'h0008, po & 16'h0008);
    mm = MEM_MICRO;
    sb = 0;
    u[2].ctrl = 8'h4c;
    put(0, 8'h4c);
    chk("quad claim", 16'hf00f, pc & 16'hf00f);
    chk("fwd", 16'h9009, po & 16'hf00f);
    u[2].ctrl = 8'hcc;
    put(0, 8'hcc);
    chk("rev", 16'h6006, po & 16'hf00f);
    s13 = 0;
    u[2].ctrl = 8'h00;
    put(0, 8'h8c);
    chk("port h", 16'h0011, pc & 16'h003f);
    put(0, 8'h4c);
    chk("port h quad", 16'h0039, pc & 16'h003f);
    s13 = 1;
    for (int p = 0; p < 4; p++) begin
      put(0, {6'h23, p[1:0]});
      chk("pol", 16'({p[0], !p[1]}), po & 16'h0003);
    end
    put(0, 8'h0c);
    chk("single", 16'h0001, pc & 16'h000f);
    chk("pad", 16'h0001, pad & 16'h0001);
    pl = 16'ha5a5;
    put(0, 8'h00);
    chk("fallback", 16'h0001, 16'({pc[0], po[0]}));
    u[0].cmp_pin = 1;
    put(0, 8'h08);
    chk("cmp drive", 16'h0003, 16'({pc[0], po[0]}));
    put(0, 8'h04);
    chk("capture", 16'h0001, 16'({pc[0], po[0]}));
    put(0, 8'h0a);
    chk("sw cmp", 16'h0001, 16'({pc[0], po[0]}));
    u[0].timer_sel = 1;
    pmb = 1;
    put(0, 8'h0c);
    chk("tick b", 16'h0001, 16'(tick & 3'h1));
    pmb = 0;
    pma = 1;
    put(0, 8'h0c);
    chk("tick a", 16'h0000, 16'(tick & 3'h1));
    pma = 0;
    u[1].compare_value_pair = 16'h1234;
    for (int k = 0; k < 2; k++) begin
      u[1].timer_sel = k[0];
      adc = !k[0];
      ta = 16'h1234;
      tcb = 16'h1234;
      put(1, 8'h0b);
      chk("trig", k[0] ? 16'h0026 : 16'h002b,
        16'({st, tra, trb, tfb, ast}));
      @(negedge mclk);
      chk("held", 16'h0000, 16'({st, tra, trb}));
      ta = 16'h0000;
      tcb = 16'h0000;
      @(negedge mclk);
    end
    u[1].ctrl = 8'h00;
    u[0].compare_value_pair = 16'h1234;
    adc = 1;
    tcb = 16'h1234;
    put(0, 8'h0b);
    chk("trig1", 16'h0014,
      16'({st, tra, trb, tfb, ast}));
    tcb = 16'h0000;
    u[2].compare_value_pair = 16'h1234;
    ta = 16'h1234;
    put(2, 8'h0b);
    chk("unit3", 16'h0000, 16'({st, tra, trb}));
    give_verdict();
  end
endmodule : eccpr_router_tb
`default_nettype wire
